// ### shared/sspcs_pkg.sv
// Purpose: constants for the relay pwm and current-loop scaler
// Assumes: 125 MHz clock, 8-bit byte register addresses
// Notes: times kept in milliseconds, currents in microamps
package sspcs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] PERIOD_MIN_MS = 16'h0064;
  localparam logic [15:0] ALARM_MIN_UA = 16'h0BB8;
  localparam logic [15:0] ALARM_MAX_UA = 16'h55F0;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PWM_LOWER = 8'h04;
  localparam logic [7:0] REG_PWM_UPPER = 8'h08;
  localparam logic [7:0] REG_PWM_ALARM = 8'h0C;
  localparam logic [7:0] REG_PERIOD = 8'h10;
  localparam logic [7:0] REG_MIN_ON = 8'h14;
  localparam logic [7:0] REG_MIN_OFF = 8'h18;
  localparam logic [7:0] REG_IN_LOWER = 8'h1C;
  localparam logic [7:0] REG_IN_UPPER = 8'h20;
  localparam logic [7:0] REG_OUT_LOWER = 8'h24;
  localparam logic [7:0] REG_OUT_UPPER = 8'h28;
  localparam logic [7:0] REG_CUR_ALARM = 8'h2C;
  localparam logic [7:0] REG_RELAY_LEVEL = 8'h30;
  localparam logic [7:0] REG_RELAY_HYST = 8'h34;
  localparam logic [7:0] REG_STATUS = 8'h38;
  localparam logic [7:0] REG_CURRENT = 8'h3C;
  localparam logic [7:0] REG_ON_TIME = 8'h40;
  // field positions
  localparam int unsigned CTRL_PWM_EN = 0;
  localparam int unsigned CTRL_RELAY_EN = 1;
  localparam int unsigned ST_PWM = 0;
  localparam int unsigned ST_RELAY = 1;
  localparam int unsigned ST_ALARM = 2;
  localparam int unsigned ST_REJECT = 3;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] PWM_LOWER_RST = 16'h0000;
  localparam logic [15:0] PWM_UPPER_RST = 16'h0064;
  localparam logic [15:0] PERIOD_RST = 16'h03E8;
  localparam logic [15:0] OUT_LOWER_RST = 16'h0FA0;
  localparam logic [15:0] OUT_UPPER_RST = 16'h4E20;
  localparam logic [15:0] CUR_ALARM_RST = 16'h0FA0;
  typedef enum logic [0:0] {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} sspcs_div_t;
  typedef enum logic [0:0] {JOB_PWM = 1'b0, JOB_CUR = 1'b1} sspcs_job_t;
endpackage : sspcs_pkg

// ### hdl/sspcs_top.sv
// Purpose: solid-state relay pwm drive, current-loop scaling, relay
// Assumes: source value and status come from logic on this clock
// Notes: one shared serial divider serves both scaling jobs
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] source below lower level gives zero on time in every period
// [R02] source above upper level keeps output on the whole period
// [R03] between levels on time is period times normalised position
// [R04] duty is on time over period of the rectangular wave
// [R05] in alarm the alarm level replaces the source for the duty
// [R06] period repeats; writes below the minimum period are refused
// [R07] output stays high at least the minimum on time
// [R08] output stays low at least the minimum off time
// [R09] current path clamps source to input lower and upper levels
// [R10] computed current clamped between output lower and upper levels
// [R11] straight-line transfer from input range to output range
// [R12] input lower gives output lower, input upper gives output upper
// [R13] current alarm when source reports error, under or over range
// [R14] alarm current is the alarm value held within 3 to 22 mA
// [R15] below-level relay: on under level-hyst, off over level+hyst
module sspcs_top
  import sspcs_pkg::*;
#(
  parameter int unsigned DW = 16,
  parameter int unsigned MS_CYC = MS_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic signed [DW-1:0] source_value,
  input wire logic source_error_state,
  input wire logic source_under_range_state,
  input wire logic source_over_range_state,
  output logic pwm_out,
  output logic relay_out,
  output logic [DW-1:0] current_ua
);
  localparam int unsigned NW = 2 * DW + 2;
  localparam int unsigned MSW = $clog2(MS_CYC + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);
  localparam logic [5:0] DIV_LAST = 6'(NW - 1);

  logic [1:0] ctrl;
  logic signed [DW-1:0] pwm_lower, pwm_upper, pwm_alarm;
  logic signed [DW-1:0] in_lower, in_upper, relay_level;
  logic [DW-1:0] period, min_on, min_off, relay_hyst;
  logic [DW-1:0] out_lower, out_upper, cur_alarm;
  logic reject;
  logic alarm;
  logic [MSW-1:0] ms_cnt;
  logic ms_tick;
  logic [DW-1:0] pos, on_ms, hold_ms;
  logic [DW-1:0] pwm_q, cur_q;
  sspcs_div_t div_state;
  sspcs_job_t job;
  logic [NW-1:0] div_num;
  logic [DW+1:0] div_rem;
  logic [DW:0] div_den;
  logic [5:0] div_cnt;

  // clamp x into lo..hi and return its offset above lo
  function automatic logic [DW:0] sspcs_pos(
    input logic signed [DW-1:0] x,
    input logic signed [DW-1:0] lo,
    input logic signed [DW-1:0] hi
  );
    logic signed [DW:0] d;
    d = 17'sd0;
    if (x <= lo)
      d = 17'sd0;
    else if (x >= hi)
      d = {hi[DW-1], hi} - {lo[DW-1], lo};
    else
      d = {x[DW-1], x} - {lo[DW-1], lo};
    return d[DW:0];
  endfunction : sspcs_pos

  // signed span hi - lo, one bit wider
  function automatic logic signed [DW:0] sspcs_span(
    input logic signed [DW-1:0] lo,
    input logic signed [DW-1:0] hi
  );
    return {hi[DW-1], hi} - {lo[DW-1], lo};
  endfunction : sspcs_span

  // alarm condition from the source channel state
  assign alarm = source_error_state | source_under_range_state
               | source_over_range_state; // [R13]

  // operand selection for the divider jobs
  logic signed [DW-1:0] pwm_x;
  logic signed [DW:0] span_p, span_c;
  logic [DW:0] diff_p, diff_c;
  logic [DW-1:0] out_span;
  logic [NW-1:0] job_num;
  logic [DW:0] job_den;
  logic job_direct;
  logic [DW-1:0] job_direct_q;
  always_comb
  begin
    pwm_x = alarm ? pwm_alarm : source_value; // [R05]
    span_p = sspcs_span(pwm_lower, pwm_upper);
    span_c = sspcs_span(in_lower, in_upper);
    diff_p = sspcs_pos(pwm_x, pwm_lower, pwm_upper); // [R01] [R02]
    diff_c = sspcs_pos(source_value, in_lower, in_upper); // [R09]
    out_span = (out_upper >= out_lower) ? out_upper - out_lower
                                        : '0;
    job_num = '0;
    job_den = '0;
    job_direct = 1'b0;
    job_direct_q = '0;
    if (job == JOB_PWM)
    begin
      job_den = span_p[DW:0];
      job_num = NW'(diff_p * period); // [R03]
      if (span_p <= 0)
      begin
        job_direct = 1'b1;
        job_direct_q = (pwm_x > pwm_upper) ? period : '0;
      end
    end
    else
    begin
      job_den = span_c[DW:0];
      job_num = NW'(diff_c * out_span); // [R11]
      if (span_c <= 0)
      begin
        job_direct = 1'b1;
        job_direct_q = (source_value > in_upper) ? out_span : '0;
      end
    end
  end

  // one restoring division step
  logic [DW+1:0] trial;
  logic take;
  logic [NW-1:0] next_num;
  logic [DW+1:0] next_rem;
  always_comb
  begin
    trial = {div_rem[DW:0], div_num[NW-1]};
    take = (trial >= {1'b0, div_den});
    next_rem = take ? trial - {1'b0, div_den} : trial;
    next_num = {div_num[NW-2:0], take};
  end

  // serial divider, alternating between the pwm and current jobs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_state <= DIV_IDLE;
      job <= JOB_PWM;
      div_num <= '0;
      div_rem <= '0;
      div_den <= '0;
      div_cnt <= '0;
      pwm_q <= '0;
      cur_q <= '0;
    end
    else
    begin
      unique case (div_state)
        DIV_IDLE:
        begin
          if (job_direct)
          begin
            if (job == JOB_PWM)
              pwm_q <= job_direct_q;
            else
              cur_q <= job_direct_q;
            job <= (job == JOB_PWM) ? JOB_CUR : JOB_PWM;
          end
          else
          begin
            div_num <= job_num;
            div_den <= job_den;
            div_rem <= '0;
            div_cnt <= '0;
            div_state <= DIV_RUN;
          end
        end
        DIV_RUN:
        begin
          div_num <= next_num;
          div_rem <= next_rem;
          div_cnt <= div_cnt + 6'h01;
          if (div_cnt == DIV_LAST)
          begin
            if (job == JOB_PWM)
              pwm_q <= next_num[DW-1:0]; // [R03] [R04]
            else
              cur_q <= next_num[DW-1:0]; // [R11]
            job <= (job == JOB_PWM) ? JOB_CUR : JOB_PWM;
            div_state <= DIV_IDLE;
          end
        end
      endcase
    end
  end

  // millisecond time base
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (ms_cnt == MS_LAST);
      ms_cnt <= (ms_cnt == MS_LAST) ? '0 : ms_cnt + 1'b1;
    end
  end

  // period position; on time latched at each period start
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pos <= '0;
      on_ms <= '0;
    end
    else if (ms_tick)
    begin
      if (pos >= period - 1'b1)
      begin
        pos <= '0; // [R06]
        on_ms <= pwm_q;
      end
      else
        pos <= pos + 1'b1;
    end
  end

  // pwm output with minimum on and off times
  logic want;
  assign want = ctrl[CTRL_PWM_EN] && (pos < on_ms); // [R04]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwm_out <= 1'b0;
      hold_ms <= '0;
    end
    else if (ms_tick)
    begin
      if (pwm_out && !want && hold_ms >= min_on)
      begin
        pwm_out <= 1'b0; // [R07]
        hold_ms <= '0;
      end
      else if (!pwm_out && want && hold_ms >= min_off)
      begin
        pwm_out <= 1'b1; // [R08]
        hold_ms <= '0;
      end
      else if (hold_ms != '1)
        hold_ms <= hold_ms + 1'b1;
    end
  end

  // current output: alarm value or clamped scaled value
  logic [DW-1:0] scaled;
  logic [DW-1:0] next_current;
  always_comb
  begin
    scaled = out_lower + cur_q; // [R12]
    if (alarm)
    begin
      if (cur_alarm < ALARM_MIN_UA)
        next_current = ALARM_MIN_UA; // [R14]
      else if (cur_alarm > ALARM_MAX_UA)
        next_current = ALARM_MAX_UA; // [R14]
      else
        next_current = cur_alarm;
    end
    else if (scaled < out_lower)
      next_current = out_lower; // [R10]
    else if (scaled > out_upper && out_upper >= out_lower)
      next_current = out_upper; // [R10]
    else
      next_current = scaled;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      current_ua <= OUT_LOWER_RST;
    else
      current_ua <= next_current;
  end

  // below-level relay with hysteresis band
  logic signed [DW+1:0] src_w, thr_lo, thr_hi;
  always_comb
  begin
    src_w = {{2{source_value[DW-1]}}, source_value};
    thr_lo = {{2{relay_level[DW-1]}}, relay_level}
           - {2'b00, relay_hyst};
    thr_hi = {{2{relay_level[DW-1]}}, relay_level}
           + {2'b00, relay_hyst};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      relay_out <= 1'b0;
    else if (!ctrl[CTRL_RELAY_EN])
      relay_out <= 1'b0;
    else if (src_w < thr_lo)
      relay_out <= 1'b1; // [R15]
    else if (src_w > thr_hi)
      relay_out <= 1'b0; // [R15]
  end

  // register writes; a too-short period is refused and flagged
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RST;
      pwm_lower <= PWM_LOWER_RST;
      pwm_upper <= PWM_UPPER_RST;
      pwm_alarm <= PWM_LOWER_RST;
      period <= PERIOD_RST;
      min_on <= '0;
      min_off <= '0;
      in_lower <= PWM_LOWER_RST;
      in_upper <= PWM_UPPER_RST;
      out_lower <= OUT_LOWER_RST;
      out_upper <= OUT_UPPER_RST;
      cur_alarm <= CUR_ALARM_RST;
      relay_level <= '0;
      relay_hyst <= '0;
    end
    else if (wr_en)
    begin
      unique case (addr)
        REG_CTRL: ctrl <= wr_data[1:0];
        REG_PWM_LOWER: pwm_lower <= wr_data[DW-1:0];
        REG_PWM_UPPER: pwm_upper <= wr_data[DW-1:0];
        REG_PWM_ALARM: pwm_alarm <= wr_data[DW-1:0];
        REG_PERIOD:
        begin
          if (wr_data[DW-1:0] >= PERIOD_MIN_MS)
            period <= wr_data[DW-1:0]; // [R06]
        end
        REG_MIN_ON: min_on <= wr_data[DW-1:0];
        REG_MIN_OFF: min_off <= wr_data[DW-1:0];
        REG_IN_LOWER: in_lower <= wr_data[DW-1:0];
        REG_IN_UPPER: in_upper <= wr_data[DW-1:0];
        REG_OUT_LOWER: out_lower <= wr_data[DW-1:0];
        REG_OUT_UPPER: out_upper <= wr_data[DW-1:0];
        REG_CUR_ALARM: cur_alarm <= wr_data[DW-1:0];
        REG_RELAY_LEVEL: relay_level <= wr_data[DW-1:0];
        REG_RELAY_HYST: relay_hyst <= wr_data[DW-1:0];
        default: ;
      endcase
    end
  end

  // sticky refusal flag; a new refusal wins over a clear
  logic period_refused;
  assign period_refused = wr_en && (addr == REG_PERIOD)
                        && (wr_data[DW-1:0] < PERIOD_MIN_MS); // [R06]
  always_ff @(posedge clk)
  begin
    if (rst)
      reject <= 1'b0;
    else if (period_refused)
      reject <= 1'b1;
    else if (wr_en && addr == REG_STATUS && wr_data[ST_REJECT])
      reject <= 1'b0;
  end

  // read data, valid the cycle after the read strobe
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      REG_CTRL: rd_mux = {30'h0, ctrl};
      REG_PWM_LOWER: rd_mux = {16'h0000, pwm_lower};
      REG_PWM_UPPER: rd_mux = {16'h0000, pwm_upper};
      REG_PWM_ALARM: rd_mux = {16'h0000, pwm_alarm};
      REG_PERIOD: rd_mux = {16'h0000, period};
      REG_MIN_ON: rd_mux = {16'h0000, min_on};
      REG_MIN_OFF: rd_mux = {16'h0000, min_off};
      REG_IN_LOWER: rd_mux = {16'h0000, in_lower};
      REG_IN_UPPER: rd_mux = {16'h0000, in_upper};
      REG_OUT_LOWER: rd_mux = {16'h0000, out_lower};
      REG_OUT_UPPER: rd_mux = {16'h0000, out_upper};
      REG_CUR_ALARM: rd_mux = {16'h0000, cur_alarm};
      REG_RELAY_LEVEL: rd_mux = {16'h0000, relay_level};
      REG_RELAY_HYST: rd_mux = {16'h0000, relay_hyst};
      REG_STATUS: rd_mux = {28'h0, reject, alarm, relay_out, pwm_out};
      REG_CURRENT: rd_mux = {16'h0000, current_ua};
      REG_ON_TIME: rd_mux = {16'h0000, on_ms};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= 32'h0000_0000;
    else if (rd_en)
      rd_data <= rd_mux;
    else
      rd_data <= 32'h0000_0000;
  end
endmodule : sspcs_top
`default_nettype wire

// ### testbench/sspcs_monitor.sv
// Purpose: port checker for the relay pwm and current scaler
// Assumes: bound to sspcs_top, one clock, synchronous reset
// Notes: helper counters track quiet inputs and pwm edge spacing
`timescale 1ns/1ps
`default_nettype none
module sspcs_monitor
  import sspcs_pkg::*;
#(
  parameter int unsigned DW = 16,
  parameter int unsigned MS_CYC = MS_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic signed [DW-1:0] source_value,
  input wire logic source_error_state,
  input wire logic source_under_range_state,
  input wire logic source_over_range_state,
  input wire logic pwm_out,
  input wire logic relay_out,
  input wire logic [DW-1:0] current_ua
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic alarm;
  logic [2:0] al_vec;
  logic [2:0] prev_al;
  logic prev_pwm;
  logic signed [DW-1:0] prev_src;
  logic [7:0] since_pwm;
  logic [7:0] quiet;
  // alarm inputs gathered
  assign al_vec = {source_error_state, source_under_range_state,
    source_over_range_state};
  assign alarm = |al_vec;
  // last seen values
  always_ff @(posedge clk)
  begin
    prev_pwm <= pwm_out;
    prev_src <= source_value;
    prev_al <= al_vec;
  end
  // cycles since the drive last changed, saturating
  always_ff @(posedge clk)
    if (rst || pwm_out != prev_pwm)
      since_pwm <= 8'h00;
    else if (since_pwm != 8'hFF)
      since_pwm <= since_pwm + 8'h01;
  // cycles with no write and steady source, saturating
  always_ff @(posedge clk)
    if (rst || wr_en || source_value != prev_src || al_vec != prev_al)
      quiet <= 8'h00;
    else if (quiet != 8'hFF)
      quiet <= quiet + 8'h01;
  property p_rst_vals;
    $fell(rst) |-> !pwm_out && !relay_out && rd_data == 32'h0
      && current_ua == OUT_LOWER_RST;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");
  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_rd_upper;
    $past(rd_en) |-> rd_data[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper half not zero");
  property p_pwm_tick;
    $changed(pwm_out) |-> since_pwm >= MS_CYC - 2;
  endproperty
  a_pwm_tick: assert property (p_pwm_tick)
    else $error("drive changed twice within one tick");
  property p_alarm_lim;
    alarm |=> current_ua >= ALARM_MIN_UA && current_ua <= ALARM_MAX_UA;
  endproperty
  a_alarm_lim: assert property (p_alarm_lim)
    else $error("alarm current outside hardware limits");
  property p_alarm_hold;
    alarm && $past(alarm) && !wr_en && !$past(wr_en) |=> $stable(current_ua);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm current moved while alarm steady");
  // worst case lag is about 105 clocks: a stale job, the other job, then ours
  property p_cur_settle;
    quiet >= 8'd120 |-> $stable(current_ua);
  endproperty
  a_cur_settle: assert property (p_cur_settle)
    else $error("current moved with steady input");
  property p_relay_hold;
    quiet >= 8'd4 |-> $stable(relay_out);
  endproperty
  a_relay_hold: assert property (p_relay_hold)
    else $error("relay moved with steady input");
endmodule : sspcs_monitor
bind sspcs_top sspcs_monitor #(.DW(DW), .MS_CYC(MS_CYC)) sspcs_monitor_i (
  .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .source_value(source_value), .source_error_state(source_error_state),
  .source_under_range_state(source_under_range_state),
  .source_over_range_state(source_over_range_state), .pwm_out(pwm_out),
  .relay_out(relay_out), .current_ua(current_ua));
`default_nettype wire

// ### testbench/sspcs_ssr_model.sv
// Purpose: solid-state relay load model measuring pulse lengths
// Assumes: a high drive makes the relay conduct
// Notes: high and low lengths are clock cycles of the last finished pulse; run_cycles counts the current one
`timescale 1ns/1ps
`default_nettype none
module sspcs_ssr_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_out,
  output logic [31:0] high_cycles,
  output logic [31:0] low_cycles,
  output logic [31:0] run_cycles
);
  logic last;
  // measure each conducting and blocking interval
  always_ff @(posedge clk)
    if (rst)
    begin
      last <= 1'b0;
      run_cycles <= 32'h0;
    end
    else
    begin
      last <= pwm_out;
      run_cycles <= (pwm_out != last) ? 32'h1 : run_cycles + 32'h1;
      if (pwm_out != last && last)
        high_cycles <= run_cycles;
      if (pwm_out != last && !last)
        low_cycles <= run_cycles;
    end
endmodule : sspcs_ssr_model
`default_nettype wire

// ### testbench/tb_sspcs_top.sv
// Purpose: self-checking bench for the relay pwm and current scaler
// Assumes: one ms tick every ten clocks to keep periods short
// Notes: pulse lengths come from the relay load model
`timescale 1ns/1ps
`default_nettype none
module tb_sspcs_top;
  import sspcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic signed [15:0] source_value = 16'sh0000;
  logic source_error_state = 1'b0;
  logic source_under_range_state = 1'b0;
  logic source_over_range_state = 1'b0;
  logic pwm_out;
  logic relay_out;
  logic [15:0] current_ua;
  logic [31:0] high_cycles;
  logic [31:0] low_cycles;
  logic [31:0] run_cycles;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sspcs_top #(.MS_CYC(10)) sspcs_top_i (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .source_value(source_value), .source_error_state(source_error_state),
    .source_under_range_state(source_under_range_state),
    .source_over_range_state(source_over_range_state), .pwm_out(pwm_out),
    .relay_out(relay_out), .current_ua(current_ua));
  sspcs_ssr_model sspcs_ssr_model_i (.clk(clk), .rst(rst), .pwm_out(pwm_out),
    .high_cycles(high_cycles), .low_cycles(low_cycles),
    .run_cycles(run_cycles));
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic cmp(input string w, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", w, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rc(input string w, input logic [7:0] a,
    input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp(w, e, rd_data);
  endtask : rc
  task automatic src(input logic signed [15:0] v, input logic [2:0] al,
    input int n);
    @(posedge clk);
    source_value <= v;
    source_error_state <= al[2];
    source_under_range_state <= al[1];
    source_over_range_state <= al[0];
    repeat (n) @(posedge clk);
    #1;
  endtask : src
  task automatic t_regs;
    rc("ctrl", REG_CTRL, 32'h0000);
    rc("out upper", REG_OUT_UPPER, 32'h4E20);
    rc("unmapped", 8'hFC, 32'h0000);
    cmp("reset current", 32'h0FA0, current_ua);
    wr(REG_PERIOD, 32'h0063);
    rc("period kept", REG_PERIOD, 32'h03E8);
    rc("reject flag", REG_STATUS, 32'h0008);
    wr(REG_STATUS, 32'h0008);
    rc("reject clear", REG_STATUS, 32'h0000);
    wr(REG_PERIOD, 32'h0064);
    rc("period min", REG_PERIOD, 32'h0064);
  endtask : t_regs
  task automatic cur(input logic signed [15:0] v, input logic [2:0] al,
    input logic [31:0] e);
    // the divider may need three jobs of 35 clocks before the new value lands
    src(v, al, 120);
    cmp("current", e, current_ua);
  endtask : cur
  task automatic t_cur;
    wr(REG_IN_LOWER, 32'h0064);
    wr(REG_IN_UPPER, 32'h01F4);
    cur(16'sh0064, 3'b000, 32'h0FA0);
    cur(16'sh01F4, 3'b000, 32'h4E20);
    cur(16'sh00C8, 3'b000, 32'h1F40);
    cur(16'sh0032, 3'b000, 32'h0FA0);
    cur(16'sh02BC, 3'b000, 32'h4E20);
    wr(REG_OUT_UPPER, 32'h03E8);
    cur(16'sh012C, 3'b000, 32'h0FA0);
    wr(REG_OUT_UPPER, 32'h4E20);
    wr(REG_CUR_ALARM, 32'h03E8);
    cur(16'sh012C, 3'b100, 32'h0BB8);
    wr(REG_CUR_ALARM, 32'h7530);
    cur(16'sh012C, 3'b010, 32'h55F0);
    wr(REG_CUR_ALARM, 32'h1388);
    cur(16'sh012C, 3'b001, 32'h1388);
  endtask : t_cur
  task automatic rel(input logic signed [15:0] v, input logic [31:0] e);
    src(v, 3'b000, 4);
    cmp("relay", e, relay_out);
  endtask : rel
  task automatic t_relay;
    wr(REG_CTRL, 32'h0003);
    wr(REG_RELAY_LEVEL, 32'h001E);
    wr(REG_RELAY_HYST, 32'h0005);
    rel(16'sh001C, 32'h0);
    rel(16'sh0018, 32'h1);
    rel(16'sh0022, 32'h1);
    rel(16'sh0024, 32'h0);
  endtask : t_relay
  task automatic t_pwm;
    src(16'sh001E, 3'b000, 3000);
    cmp("on cycles", 32'h012C, high_cycles);
    cmp("off cycles", 32'h02BC, low_cycles);
    rc("on time", REG_ON_TIME, 32'h001E);
    src(-16'sh0005, 3'b000, 3000);
    cmp("zero duty", 32'h1, !pwm_out && run_cycles >= 32'h07D0);
    // full on starts one ms tick after the new on time is latched at a period start
    src(16'sh0096, 3'b000, 3300);
    cmp("full duty", 32'h1, pwm_out && run_cycles >= 32'h07D0);
    wr(REG_PWM_ALARM, 32'h0032);
    src(16'sh000A, 3'b100, 3000);
    cmp("alarm duty", 32'h01F4, high_cycles);
    wr(REG_MIN_ON, 32'h0032);
    src(16'sh000A, 3'b000, 3000);
    cmp("min on", 32'h1, high_cycles >= 32'h01F4
      && high_cycles <= 32'h01FE);
    wr(REG_MIN_ON, 32'h0000);
    wr(REG_MIN_OFF, 32'h003C);
    src(16'sh005A, 3'b000, 3000);
    cmp("min off", 32'h1, low_cycles >= 32'h0258);
  endtask : t_pwm
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cur();
    t_relay();
    t_pwm();
    stop_test();
  end
endmodule : tb_sspcs_top
`default_nettype wire
